// File: design/ber_pkg.sv
// Purpose: constants and types of the bridge error reporting unit
// Assumes: register index = byte-address / 4, one 8- or 32-bit register per word
// Notes: all resets are zero
// Contract
// - correct single-bit memory errors silently
// - count single-bit errors, save their address
// - count above trigger level raises trigger error
// - trigger error enable/status bit 2, W1C
// - cpu trigger error: clear pci flag, capture
// - pci access error: set pci flag, capture
// - uncorrectable read error raises multi-bit error
// - multi-bit enable/status bit 3, W1C
// - cpu multi-bit error: capture, cpu number bit 7
// - fatal request sampled as plain level
// - fatal request holds MCP when option enabled
// - fatal request ignored while error outstanding
// - fatal request never blocks other error detection
// - bus MCP pulse then MCP off until clear; the code releases it once no error is outstanding
// - record, report, then suppress until cleared
// - reporting never disturbs bus or memory traffic
// - MCP pulses two clocks for its error classes
// - terminable transfer error ends with TEA
// - target system error pulses SERR one PCI clock
// - receive data parity error pulses PERR
// - no status while outstanding, reports still issued
package ber_pkg;
	localparam logic [7:0] IDX_SB_COUNT = 8'hb8;
	localparam logic [7:0] IDX_SB_LEVEL = 8'hb9;
	localparam logic [7:0] IDX_OPTIONS = 8'hba;
	localparam logic [7:0] IDX_ERR_EN = 8'hc0;
	localparam logic [7:0] IDX_ERR_STS = 8'hc1;
	localparam logic [7:0] IDX_CPU_INFO = 8'hc3;
	localparam logic [7:0] IDX_PCI_INFO = 8'hc7;
	localparam logic [7:0] IDX_CAP_ADDR = 8'hc8;
	localparam logic [7:0] IDX_SB_ADDR = 8'hcc;
	localparam int BIT_TRIG = 2;
	localparam int BIT_MULTI = 3;
	localparam int BIT_PCI_CYC = 4;
	localparam int BIT_SB_CPU = 5;
	localparam int BIT_MB_CPU = 7;
	localparam int BIT_MCP_EN = 0;
	localparam int BIT_ECC_MODE = 1;
	localparam logic [7:0] STS_MASK = 8'h0c;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [31:0] RST_WORD = 32'h00000000;
	localparam logic [1:0] MCP_CLKS = 2'h2;
	localparam int CLK_NS = 10;
	localparam int PCI_CLK_NS = 30;
	localparam int PCI_PULSE_CYC = (PCI_CLK_NS + CLK_NS - 1) / CLK_NS;
	typedef struct packed {
		logic [7:0] cnt;
		logic [7:0] lvl;
		logic [7:0] opt;
		logic [7:0] en;
		logic [7:0] sts;
		logic [7:0] cinfo;
		logic [7:0] pinfo;
		logic [31:0] cap;
		logic [31:0] sbaddr;
		logic [31:0] rdata;
		logic [1:0] mcp_cnt;
		logic mcp_blk;
		logic fatal;
		logic tea;
		logic [3:0] serr_cnt;
		logic [3:0] perr_cnt;
		logic [63:0] corr;
	} ber_state_t;
	typedef struct packed {
		logic [31:0] addr;
		logic is_pci;
		logic cpu_num;
		logic [7:0] cpu_ctrl;
		logic [3:0] pci_ctrl;
	} ber_access_t;
endpackage

// File: design/ber_top.sv
// Purpose: ecc error counting, capture and error reporting to cpu and pci
// Assumes: register port byte address, index in bits [9:2]; inputs synchronous
// Notes: SERR and PERR pulses last one PCI clock counted in CPU clocks
`timescale 1ns/10ps
module ber_top #(
	parameter logic [3:0] PCI_CYC = 4'(ber_pkg::PCI_PULSE_CYC)
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RST,
	// register port
	input wire logic [9:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [31:0] REG_RDATA,
	// memory read path
	input wire logic [63:0] MEM_DATA,
	input wire logic [31:0] MEM_ADDR,
	input wire logic ECC_SBE,
	input wire logic [5:0] ECC_BIT,
	input wire logic ECC_MBE,
	output logic [63:0] CORR_DATA,
	// access that caused the memory read
	input wire ber_pkg::ber_access_t ACC,
	// cpu bus error sources and reports
	input wire logic FATAL_REQ,
	input wire logic XFER_ERR,
	input wire logic LATE_ERR,
	output logic MCP_N,
	output logic TEA_N,
	// pci error sources and reports
	input wire logic PCI_SYS_ERR,
	input wire logic PCI_DPAR_ERR,
	input wire logic PCI_RX_DATA,
	output logic SERR_N_O,
	output logic SERR_N_OE,
	output logic PERR_N_O,
	output logic PERR_N_OE
);
	ber_pkg::ber_state_t s_q, s_d;
	logic [7:0] idx;
	logic outst, ecc_on, sbe, trig_err, mbe_err, rec, mcp_ev;
	logic [7:0] cnt_inc;

	if (PCI_CYC == 4'h0) begin : g_bad_cyc
		$error("PCI_CYC must be at least one clock");
	end

	function automatic logic hit(input logic [7:0] i, input logic [7:0] want);
		hit = (i == want);
	endfunction

	always_comb begin
		idx = REG_ADDR[9:2];
		ecc_on = s_q.opt[ber_pkg::BIT_ECC_MODE];
		sbe = ECC_SBE & ecc_on;
		// saturate so a long error burst cannot wrap below the trigger level
		cnt_inc = (s_q.cnt == 8'hff) ? s_q.cnt : s_q.cnt + 8'h01;
		trig_err = sbe & (cnt_inc > s_q.lvl) & s_q.en[ber_pkg::BIT_TRIG];
		mbe_err = ECC_MBE & ecc_on & s_q.en[ber_pkg::BIT_MULTI];
		outst = |(s_q.sts & ber_pkg::STS_MASK);
		rec = (trig_err | mbe_err) & ~outst;
		mcp_ev = trig_err | mbe_err | LATE_ERR;
		s_d = s_q;
		// correction needs no report of its own
		s_d.corr = MEM_DATA ^ (sbe ? (64'h1 << ECC_BIT) : 64'h0);
		if (REG_WR) begin
			if (hit(idx, ber_pkg::IDX_SB_COUNT))
				s_d.cnt = REG_WDATA[7:0];
			if (hit(idx, ber_pkg::IDX_SB_LEVEL))
				s_d.lvl = REG_WDATA[7:0];
			if (hit(idx, ber_pkg::IDX_OPTIONS))
				s_d.opt = REG_WDATA[7:0];
			if (hit(idx, ber_pkg::IDX_ERR_EN))
				s_d.en = REG_WDATA[7:0];
			if (hit(idx, ber_pkg::IDX_ERR_STS))
				s_d.sts = s_q.sts & ~REG_WDATA[7:0];
			if (hit(idx, ber_pkg::IDX_CAP_ADDR))
				s_d.cap = REG_WDATA;
			if (hit(idx, ber_pkg::IDX_SB_ADDR))
				s_d.sbaddr = REG_WDATA;
		end
		// hardware events come after the write so a set beats a clear
		if (sbe) begin
			s_d.cnt = cnt_inc;
			s_d.sbaddr = MEM_ADDR;
		end
		if (rec) begin
			if (trig_err)
				s_d.sts[ber_pkg::BIT_TRIG] = 1'b1;
			if (mbe_err)
				s_d.sts[ber_pkg::BIT_MULTI] = 1'b1;
			s_d.cap = ACC.addr;
			s_d.pinfo[ber_pkg::BIT_PCI_CYC] = ACC.is_pci;
			if (ACC.is_pci) begin
				s_d.pinfo[3:0] = ACC.pci_ctrl;
			end else begin
				s_d.cinfo = ACC.cpu_ctrl;
				if (mbe_err)
					s_d.pinfo[ber_pkg::BIT_MB_CPU] = ACC.cpu_num;
				else
					s_d.pinfo[ber_pkg::BIT_SB_CPU] = ACC.cpu_num;
			end
		end
		// plain level, no history; blind while an error is outstanding
		s_d.fatal = FATAL_REQ & ~outst;
		if (mcp_ev)
			s_d.mcp_cnt = ber_pkg::MCP_CLKS;
		else if (s_q.mcp_cnt != 2'h0)
			s_d.mcp_cnt = s_q.mcp_cnt - 2'h1;
		// after a bus pulse the fatal hold stays off until no error is outstanding
		if (s_q.mcp_cnt == 2'h1 && !mcp_ev)
			s_d.mcp_blk = 1'b1;
		else if (!outst && s_q.mcp_cnt == 2'h0)
			s_d.mcp_blk = 1'b0;
		s_d.tea = XFER_ERR;
		if (PCI_SYS_ERR)
			s_d.serr_cnt = PCI_CYC;
		else if (s_q.serr_cnt != 4'h0)
			s_d.serr_cnt = s_q.serr_cnt - 4'h1;
		if (PCI_DPAR_ERR && PCI_RX_DATA)
			s_d.perr_cnt = PCI_CYC;
		else if (s_q.perr_cnt != 4'h0)
			s_d.perr_cnt = s_q.perr_cnt - 4'h1;
		s_d.rdata = 32'h0;
		if (REG_RD) begin
			unique case (idx)
				ber_pkg::IDX_SB_COUNT: s_d.rdata = {24'h0, s_q.cnt};
				ber_pkg::IDX_SB_LEVEL: s_d.rdata = {24'h0, s_q.lvl};
				ber_pkg::IDX_OPTIONS: s_d.rdata = {24'h0, s_q.opt};
				ber_pkg::IDX_ERR_EN: s_d.rdata = {24'h0, s_q.en};
				ber_pkg::IDX_ERR_STS: s_d.rdata = {24'h0, s_q.sts};
				ber_pkg::IDX_CPU_INFO: s_d.rdata = {24'h0, s_q.cinfo};
				ber_pkg::IDX_PCI_INFO: s_d.rdata = {24'h0, s_q.pinfo};
				ber_pkg::IDX_CAP_ADDR: s_d.rdata = s_q.cap;
				ber_pkg::IDX_SB_ADDR: s_d.rdata = s_q.sbaddr;
				default: s_d.rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			s_q <= '0;
			s_q.cnt <= ber_pkg::RST_BYTE;
			s_q.cap <= ber_pkg::RST_WORD;
		end else begin
			s_q <= s_d;
		end
	end

	// reports are side outputs only; no bus or memory state depends on them
	assign MCP_N = ~((s_q.mcp_cnt != 2'h0) |
		(s_q.fatal & s_q.opt[ber_pkg::BIT_MCP_EN] & ~s_q.mcp_blk));
	assign TEA_N = ~s_q.tea;
	// SERR is open drain: only ever driven low
	assign SERR_N_O = 1'b0;
	assign SERR_N_OE = (s_q.serr_cnt != 4'h0);
	assign PERR_N_O = (s_q.perr_cnt == 4'h0);
	assign PERR_N_OE = (s_q.perr_cnt != 4'h0);
	assign REG_RDATA = s_q.rdata;
	assign CORR_DATA = s_q.corr;

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);

	AST_SBE_COUNT: assert property (sbe && s_q.cnt != 8'hff |=> s_q.cnt == $past(s_q.cnt) + 8'h01)
		else $error("single-bit count did not advance");
	AST_SBE_ADDR: assert property (sbe |=> s_q.sbaddr == $past(MEM_ADDR))
		else $error("single-bit address not saved");
	AST_TRIG_STS: assert property (trig_err && !outst |=> s_q.sts[2] && s_q.cap == $past(ACC.addr))
		else $error("trigger error not recorded");
	AST_MBE_STS: assert property (mbe_err && !outst && !ACC.is_pci |=> s_q.sts[3] && !s_q.pinfo[4])
		else $error("multi-bit error not recorded");
	AST_HOLD: assert property (outst && !REG_WR |=> $stable(s_q.cap) && $stable(s_q.pinfo))
		else $error("capture changed while error outstanding");
	AST_MCP_PULSE: assert property (mcp_ev |=> !MCP_N ##1 !MCP_N)
		else $error("MCP pulse shorter than two clocks");
	AST_FATAL_BLIND: assert property (outst |=> !s_q.fatal)
		else $error("fatal request sampled while error outstanding");
	// a pulse ending now sets the block, and an options write may drop the enable
	AST_FATAL_MCP: assert property (FATAL_REQ && !outst && s_q.opt[ber_pkg::BIT_MCP_EN] && !s_q.mcp_blk && !mcp_ev
		&& s_q.mcp_cnt != 2'h1 && !REG_WR |=> !MCP_N)
		else $error("fatal request did not hold MCP");
	AST_FATAL_OFF: assert property (!s_q.opt[ber_pkg::BIT_MCP_EN] && s_q.mcp_cnt == 2'h0 && !mcp_ev && !REG_WR
		|=> MCP_N)
		else $error("MCP asserted while disabled");
	AST_MCP_BLOCK: assert property (s_q.mcp_blk && outst && s_q.mcp_cnt == 2'h0 && !mcp_ev && !REG_WR
		|=> MCP_N)
		else $error("MCP asserted while blocked after a bus pulse");
	AST_PCI_CAP: assert property (mbe_err && !outst && ACC.is_pci
		|=> s_q.pinfo[ber_pkg::BIT_PCI_CYC] && s_q.cap == $past(ACC.addr))
		else $error("pci access error not captured");
	AST_MBE_OFF: assert property (!s_q.en[ber_pkg::BIT_MULTI] && !s_q.sts[ber_pkg::BIT_MULTI]
		|=> !s_q.sts[ber_pkg::BIT_MULTI])
		else $error("multi-bit status set while disabled");
	AST_STS_W1C: assert property (REG_WR && hit(idx, ber_pkg::IDX_ERR_STS) && !rec
		|=> (s_q.sts & $past(REG_WDATA[7:0])) == 8'h00)
		else $error("status bit not cleared by write of one");
	AST_SBE_SAT: assert property (sbe && s_q.cnt == 8'hff |=> s_q.cnt == 8'hff)
		else $error("single-bit count wrapped");
	AST_TEA_ONE: assert property (!XFER_ERR |=> TEA_N)
		else $error("TEA without transfer error");
	AST_RDATA_IDLE: assert property (!REG_RD |=> REG_RDATA == 32'h00000000)
		else $error("read data outside read cycle");
	AST_TEA: assert property (XFER_ERR |=> !TEA_N)
		else $error("TEA missing after transfer error");
	AST_SERR: assert property (PCI_SYS_ERR |=> SERR_N_OE && !SERR_N_O)
		else $error("SERR not driven after system error");
	AST_PERR: assert property (PCI_DPAR_ERR && PCI_RX_DATA |=> PERR_N_OE && !PERR_N_O)
		else $error("PERR not driven after parity error");
endmodule

// File: verif/ber_fatal_src.sv
// Purpose: outside logic that raises the fatal error request
// Assumes: shares the bridge clock
// Notes: mask and sticky status live here, the bridge keeps none
`timescale 1ns/10ps
module ber_fatal_src (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// catastrophe source and its mask
	input wire logic fault,
	input wire logic mask,
	// request and own status
	output logic fatal_req,
	output logic seen_q
);
	assign fatal_req = fault & ~mask;
	always_ff @(posedge clk) begin
		seen_q <= rst ? 1'b0 : (seen_q | fatal_req);
	end
endmodule

// File: verif/bridge_error_reporting_unit_tb.sv
// Purpose: self-checking bench of the error reporting unit
// Assumes: register index sits in address bits [9:2]
// Notes: short pci pulse so the oe count stays small
`timescale 1ns/10ps
module bridge_error_reporting_unit_tb;
	localparam logic [3:0] PC = 4'h2;
	logic CLK, RST, REG_WR, REG_RD, ECC_SBE, ECC_MBE, XFER_ERR, LATE_ERR, PCI_SYS_ERR, PCI_DPAR_ERR, PCI_RX_DATA;
	logic FATAL_REQ, fault, mask, seen, MCP_N, TEA_N, SERR_N_O, SERR_N_OE, PERR_N_O, PERR_N_OE;
	logic [9:0] REG_ADDR;
	logic [31:0] REG_WDATA, REG_RDATA, MEM_ADDR, cap;
	logic [63:0] MEM_DATA, CORR_DATA;
	logic [5:0] ECC_BIT;
	logic [31:0] seed = 32'h00009512;
	ber_pkg::ber_access_t ACC;
	int fails = 0, compares = 0, n_sb = 0, n;
	ber_top #(.PCI_CYC(PC)) i_ber_top (.CLK, .RST, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA,
		.MEM_DATA, .MEM_ADDR, .ECC_SBE, .ECC_BIT, .ECC_MBE, .CORR_DATA, .ACC, .FATAL_REQ, .XFER_ERR,
		.LATE_ERR, .MCP_N, .TEA_N, .PCI_SYS_ERR, .PCI_DPAR_ERR, .PCI_RX_DATA, .SERR_N_O, .SERR_N_OE,
		.PERR_N_O, .PERR_N_OE);
	ber_fatal_src i_ber_fatal_src (.clk(CLK), .rst(RST), .fault, .mask, .fatal_req(FATAL_REQ), .seen_q(seen));
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	task automatic print_verdict();
		if (fails == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		compares++;
		if (g !== e) begin
			fails++;
			$display("wrong value at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] i, input logic [31:0] d);
		@(posedge CLK);
		REG_ADDR <= {i, 2'b00};
		REG_WDATA <= d;
		REG_WR <= 1'b1;
		@(posedge CLK);
		REG_WR <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] i, input logic [31:0] m, input logic [31:0] e);
		@(posedge CLK);
		REG_ADDR <= {i, 2'b00};
		REG_RD <= 1'b1;
		@(posedge CLK);
		REG_RD <= 1'b0;
		#1 chk(REG_RDATA & m, e);
	endtask
	// one memory read with a random access; returns just after the taking edge
	task automatic ev(input logic sbe, input logic mbe, input logic pci);
		@(posedge CLK);
		seed = xs(seed);
		ACC <= {seed, pci, seed[0], seed[15:8], seed[19:16]};
		MEM_ADDR <= seed;
		MEM_DATA <= {seed, ~seed};
		ECC_BIT <= seed[29:24];
		ECC_SBE <= sbe;
		ECC_MBE <= mbe;
		@(posedge CLK);
		ECC_SBE <= 1'b0;
		ECC_MBE <= 1'b0;
		#1;
	endtask
	task automatic mcp2();
		chk(MCP_N, 0);
		@(posedge CLK);
		#1 chk(MCP_N, 0);
		@(posedge CLK);
		#1 chk(MCP_N, 1);
	endtask
	initial begin
		CLK = 1'b0;
		forever #5 CLK = ~CLK;
	end
	initial begin
		#300000;
		fails++;
		print_verdict();
	end
	initial begin
		RST = 1'b1;
		{REG_WR, REG_RD, ECC_SBE, ECC_MBE, XFER_ERR, LATE_ERR, PCI_SYS_ERR, PCI_DPAR_ERR, PCI_RX_DATA, fault, mask} = '0;
		{REG_ADDR, REG_WDATA, MEM_ADDR, MEM_DATA, ECC_BIT} = '0;
		ACC = '0;
		repeat (5) @(posedge CLK);
		RST <= 1'b0;
		rdc(ber_pkg::IDX_ERR_STS, 32'hff, 0);
		#10 chk(REG_RDATA, 64'h0);
		wr(ber_pkg::IDX_OPTIONS, 32'h02);
		wr(ber_pkg::IDX_ERR_EN, 32'h0c);
		wr(ber_pkg::IDX_SB_LEVEL, 32'h01);
		for (int k = 0; k < 2; k++) begin
			ev(1'b1, 1'b0, 1'b0);
			n_sb++;
			chk(CORR_DATA, {seed, ~seed} ^ (64'h1 << seed[29:24]));
			if (k == 0) chk(MCP_N, 1);
		end
		rdc(ber_pkg::IDX_SB_COUNT, 32'hff, n_sb);
		rdc(ber_pkg::IDX_SB_ADDR, '1, seed);
		rdc(ber_pkg::IDX_ERR_STS, 32'h0c, 32'h04);
		rdc(ber_pkg::IDX_PCI_INFO, 32'h30, {26'h0, seed[0], 5'h0});
		rdc(ber_pkg::IDX_CAP_ADDR, '1, seed);
		rdc(ber_pkg::IDX_CPU_INFO, 32'hff, seed[15:8]);
		cap = seed;
		ev(1'b0, 1'b1, 1'b0);
		mcp2();
		rdc(ber_pkg::IDX_ERR_STS, 32'h0c, 32'h04);
		rdc(ber_pkg::IDX_CAP_ADDR, '1, cap);
		wr(ber_pkg::IDX_ERR_STS, 32'h04);
		rdc(ber_pkg::IDX_ERR_STS, 32'h0c, 0);
		for (int p = 0; p < 2; p++) begin
			ev(1'b0, 1'b1, p[0]);
			rdc(ber_pkg::IDX_ERR_STS, 32'h0c, 32'h08);
			rdc(ber_pkg::IDX_CAP_ADDR, '1, seed);
			rdc(ber_pkg::IDX_PCI_INFO, p ? 32'h1f : 32'h90, p ? {27'h1, seed[19:16]} : {24'h0, seed[0], 7'h0});
			wr(ber_pkg::IDX_ERR_STS, 32'h08);
		end
		wr(ber_pkg::IDX_ERR_EN, 32'h00);
		ev(1'b0, 1'b1, 1'b0);
		rdc(ber_pkg::IDX_ERR_STS, 32'h0c, 0);
		wr(ber_pkg::IDX_ERR_EN, 32'h0c);
		@(posedge CLK);
		XFER_ERR <= 1'b1;
		@(posedge CLK);
		XFER_ERR <= 1'b0;
		#1 chk(TEA_N, 0);
		@(posedge CLK);
		#1 chk(TEA_N, 1);
		@(posedge CLK);
		LATE_ERR <= 1'b1;
		@(posedge CLK);
		LATE_ERR <= 1'b0;
		#1 mcp2();
		for (int q = 0; q < 2; q++) begin
			@(posedge CLK);
			PCI_SYS_ERR <= !q;
			PCI_DPAR_ERR <= q[0];
			PCI_RX_DATA <= q[0];
			@(posedge CLK);
			{PCI_SYS_ERR, PCI_DPAR_ERR, PCI_RX_DATA} <= 3'h0;
			n = 0;
			repeat (PC + 2) begin
				#1 n += q ? (PERR_N_OE && !PERR_N_O) : (SERR_N_OE && !SERR_N_O);
				@(posedge CLK);
			end
			chk(n, PC);
		end
		wr(ber_pkg::IDX_OPTIONS, 32'h02);
		fault <= 1'b1;
		repeat (3) @(posedge CLK);
		#1 chk(MCP_N, 1);
		wr(ber_pkg::IDX_OPTIONS, 32'h03);
		repeat (3) @(posedge CLK);
		#1 chk(MCP_N, 0);
		ev(1'b0, 1'b1, 1'b0);
		repeat (2) @(posedge CLK);
		#1 chk(MCP_N, 1);
		repeat (4) @(posedge CLK);
		#1 chk(MCP_N, 1);
		rdc(ber_pkg::IDX_ERR_STS, 32'h0c, 32'h08);
		wr(ber_pkg::IDX_ERR_STS, 32'h08);
		repeat (3) @(posedge CLK);
		#1 chk(MCP_N, 0);
		chk(seen, 1);
		mask <= 1'b1;
		repeat (3) @(posedge CLK);
		#1 chk(MCP_N, 1);
		print_verdict();
	end
endmodule
